/* File: dv/tb.sv */
// Purpose: directed bench for the watchdog configuration decoder
// Assumes: classic wishbone, full byte selects on every access except one lane-1 control write
// Notes:   each state check reads status and also looks at the ports
`timescale 1ns/100ps
module tb;
  import wdcfg_pkg::*;
  localparam logic [17:0] A_CFG = 18'h2_0024;
  localparam logic [17:0] A_CTL = 18'h2_0040;
  localparam logic [17:0] A_STA = 18'h2_0044;
  logic        clk_i = 1'b0, rst_i = 1'b1, sleep_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic        ack_o, wdt_run_o, wdt_keyed_o;
  logic [13:0] cfg_word_i = 14'h3fff, cfg_cur;
  logic [17:0] adr_i = 18'h0;
  logic [3:0]  sel_i = 4'hf, wsel = 4'hf;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  logic [2:0]  wdt_window_o;
  logic [4:0]  wdt_period_o, wdt_exponent_o;
  wdcfg_src_e  wdt_src_o;
  int          failures = 0, n_compared = 0;

  wdcfg_top wdcfg_top_i (.clk_i(clk_i), .rst_i(rst_i), .cfg_word_i(cfg_word_i), .sleep_i(sleep_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .wdt_run_o(wdt_run_o), .wdt_src_o(wdt_src_o), .wdt_window_o(wdt_window_o),
    .wdt_period_o(wdt_period_o), .wdt_exponent_o(wdt_exponent_o), .wdt_keyed_o(wdt_keyed_o));

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic test_done();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // request held until ack is seen at a rising edge
  task automatic wb(input logic w, input logic [17:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    sel_i <= wsel;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (n >= 20) begin
      failures++;
      test_done();
    end
  endtask

  // the word changes after release, so a re-sampling design shows up
  task automatic do_reset(input logic [13:0] c);
    cfg_cur = c;
    rst_i <= 1'b1;
    cfg_word_i <= c;
    sleep_i <= 1'b0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    cfg_word_i <= ~c;
  endtask

  task automatic expect_state(input logic run, input logic [2:0] src, input logic [2:0] win, input logic [4:0] per);
    logic [31:0] e;
    e = {11'h0, src == 3'h0, cfg_cur[4:0] == 5'h1f, cfg_cur[10:8] == 3'h7, cfg_cur[10:8] != 3'h7,
         (per <= 5'h12) ? per + 5'h05 : 5'h05, per, win, src, run};
    wb(1'b0, A_STA, 32'h0, rd);
    cmp(rd, e);
    cmp({14'h0, wdt_keyed_o, wdt_exponent_o, wdt_period_o, wdt_window_o, wdt_src_o, wdt_run_o},
        e & 32'h0003_ffff);
  endtask

  task automatic sc_erased();
    do_reset(14'h3fff);
    expect_state(1'b1, 3'h1, 3'h7, 5'h0b);
    sleep_i <= 1'b1;
    expect_state(1'b1, 3'h1, 3'h7, 5'h0b);
    wb(1'b1, A_CTL, 32'h0000_0326, rd);
    expect_state(1'b1, 3'h2, 3'h3, 5'h12);
    wsel = 4'h2;
    wb(1'b1, A_CTL, 32'h0000_0600, rd);
    wsel = 4'hf;
    expect_state(1'b0, 3'h0, 3'h3, 5'h02);
    wb(1'b1, A_CFG, 32'h0000_0000, rd);
    wb(1'b0, A_CFG, 32'h0000_0000, rd);
    cmp(rd, 32'h0000_3fff);
    wb(1'b0, 18'h2_0000, 32'h0000_0000, rd);
    cmp(rd, 32'h0000_0000);
  endtask

  task automatic sc_locked();
    do_reset(14'h0d53);
    expect_state(1'b1, 3'h2, 3'h5, 5'h13);
    wb(1'b1, A_CTL, 32'h0000_0326, rd);
    sleep_i <= 1'b1;
    expect_state(1'b0, 3'h2, 3'h5, 5'h13);
  endtask

  task automatic sc_sen();
    do_reset(14'h1020);
    expect_state(1'b0, 3'h3, 3'h0, 5'h00);
    wb(1'b1, A_CTL, 32'h0000_0001, rd);
    sleep_i <= 1'b1;
    expect_state(1'b1, 3'h3, 3'h0, 5'h00);
    wb(1'b1, A_CTL, 32'h0000_0000, rd);
    expect_state(1'b0, 3'h3, 3'h0, 5'h00);
  endtask

  task automatic sc_off();
    do_reset(14'h0612);
    wb(1'b1, A_CTL, 32'h0000_0001, rd);
    expect_state(1'b0, 3'h1, 3'h6, 5'h12);
  endtask

  initial begin
    sc_erased();
    sc_locked();
    sc_sen();
    sc_off();
    test_done();
  end
endmodule

/* File: dv/wdcfg_top_assertions.sv */
// Purpose: port checks for the watchdog configuration decoder
// Assumes: config word is taken on the last edge with reset high
// Notes:   settings are judged from the third edge after release
`timescale 1ns/100ps
module wdcfg_top_assertions (
  // clock and reset
  input wire logic                        clk_i,
  input wire logic                        rst_i,
  // configuration, core state and bus
  input wire logic [wdcfg_pkg::CFG_W-1:0] cfg_word_i,
  input wire logic                        sleep_i,
  input wire logic                        cyc_i,
  input wire logic                        stb_i,
  input wire logic                        ack_o,
  // decoded settings
  input wire logic                        wdt_run_o,
  input wire wdcfg_pkg::wdcfg_src_e       wdt_src_o,
  input wire logic [2:0]                  wdt_window_o,
  input wire logic [4:0]                  wdt_period_o,
  input wire logic [4:0]                  wdt_exponent_o,
  input wire logic                        wdt_keyed_o
);
  import wdcfg_pkg::*;
  logic [13:0] cfg_q;
  logic [1:0]  up_q;
  logic        ok;
  // own copy of the word, so a design that re-samples it is caught
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_q <= cfg_word_i;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      up_q <= 2'h0;
    end else if (up_q != 2'h2) begin
      up_q <= up_q + 2'h1;
    end
  end
  assign ok = (up_q == 2'h2);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("no ack after request");
  chk_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  chk_src_fixed: assert property (ok && cfg_q[13:11] < 3'h3 |-> 3'(wdt_src_o) == cfg_q[13:11] + 3'h1)
    else $error("wrong clock source");
  chk_win_fixed: assert property (ok && cfg_q[10:8] != 3'h7 |-> wdt_window_o == cfg_q[10:8])
    else $error("locked window changed");
  chk_key_flag: assert property (ok |-> wdt_keyed_o == (cfg_q[10:8] != 3'h7))
    else $error("keyed flag wrong");
  chk_always_run: assert property (ok && cfg_q[6:5] == 2'h3 && wdt_src_o != WDCFG_SRC_NONE |-> wdt_run_o)
    else $error("always mode not running");
  chk_sleep_stop: assert property (ok && cfg_q[6:5] == 2'h2 |=>
    wdt_run_o == (!$past(sleep_i) && wdt_src_o != WDCFG_SRC_NONE))
    else $error("awake mode run wrong");
  chk_rsvd_stop: assert property (wdt_src_o == WDCFG_SRC_NONE |-> !wdt_run_o)
    else $error("running without a reference");
  chk_off_mode: assert property (cfg_q[6:5] == 2'h0 |-> !wdt_run_o)
    else $error("off mode running");
  chk_period_fix: assert property (ok && cfg_q[4:0] != 5'h1f |-> wdt_period_o == cfg_q[4:0])
    else $error("fixed period wrong");
  chk_exp_map: assert property (wdt_exponent_o == ((wdt_period_o <= 5'h12) ? wdt_period_o + 5'h05 : 5'h05))
    else $error("exponent wrong");
  chk_period_load: assert property (up_q == 2'h1 && cfg_q[4:0] == 5'h1f |=> wdt_period_o == 5'h0b)
    else $error("period load wrong");
endmodule

bind wdcfg_top wdcfg_top_assertions wdcfg_top_assertions_i (.clk_i(clk_i), .rst_i(rst_i),
  .cfg_word_i(cfg_word_i), .sleep_i(sleep_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
  .wdt_run_o(wdt_run_o), .wdt_src_o(wdt_src_o), .wdt_window_o(wdt_window_o), .wdt_period_o(wdt_period_o),
  .wdt_exponent_o(wdt_exponent_o), .wdt_keyed_o(wdt_keyed_o));

/* File: logic/wdcfg_decode.sv */
// Purpose: combinational decode of latched watchdog settings
// Assumes: inputs are stable register outputs
// Notes:   pure logic, the top registers every result except win_sw, per_sw and reserved
`timescale 1ns/100ps
module wdcfg_decode (
  // latched configuration, software state and core sleep state
  input  wire wdcfg_pkg::wdcfg_cfg_s cfg_i,
  input  wire logic                  sen_i,
  input  wire logic [2:0]            sw_clk_i,
  input  wire logic [2:0]            sw_win_i,
  input  wire logic [4:0]            period_i,
  input  wire logic                  sleep_i,
  // decoded settings
  output wdcfg_pkg::wdcfg_dec_s      dec_o
);
  import wdcfg_pkg::*;

  logic [2:0] clk_code;

  always_comb begin
    dec_o = '0;
    clk_code = (cfg_i.ccs == CCS_SW) ? sw_clk_i : cfg_i.ccs;
    unique case (clk_code)
      CCS_LF:  dec_o.src = WDCFG_SRC_LF;
      CCS_MF:  dec_o.src = WDCFG_SRC_MF;
      CCS_SEC: dec_o.src = WDCFG_SRC_SEC;
      default: dec_o.src = WDCFG_SRC_NONE;
    endcase
    // reserved codes leave the timer with no reference
    dec_o.reserved = (dec_o.src == WDCFG_SRC_NONE);
    dec_o.win_sw = (cfg_i.cws == CWS_SW);
    dec_o.keyed  = (cfg_i.cws != CWS_SW);
    dec_o.window = dec_o.win_sw ? sw_win_i : cfg_i.cws;
    unique case (cfg_i.mode)
      MODE_ALWAYS: dec_o.run = 1'b1;
      MODE_AWAKE:  dec_o.run = ~sleep_i;
      MODE_SEN:    dec_o.run = sen_i;
      MODE_OFF:    dec_o.run = 1'b0;
    endcase
    // divide by two to the code plus five; codes above 0x12 give five
    dec_o.per_sw   = (cfg_i.cps == CPS_SW);
    dec_o.exponent = (period_i <= CPS_MAX_FIX) ? 5'(period_i + EXP_OFFSET) : EXP_MIN;
  end

endmodule

/* File: logic/wdcfg_pkg.sv */
// Purpose: shared constants and types for the watchdog configuration decoder
// Assumes: 14-bit configuration word, classic wishbone with 32-bit data
// Notes:   register indices are word indices, byte address is four times the index
package wdcfg_pkg;

  // configuration word layout
  localparam int unsigned CFG_W         = 14;
  localparam int unsigned CCS_LSB       = 11;
  localparam int unsigned CWS_LSB       = 8;
  localparam int unsigned MODE_LSB      = 5;
  localparam int unsigned CPS_LSB       = 0;
  localparam logic [13:0] CFG_ERASED    = 14'h3fff;

  // register map (word indices)
  localparam int unsigned ADR_W         = 18;
  localparam logic [15:0] IDX_CFG_WORD  = 16'h8009;
  localparam logic [15:0] IDX_CTRL      = 16'h8010;
  localparam logic [15:0] IDX_STAT      = 16'h8011;

  // control register fields
  localparam int unsigned CTRL_SEN      = 0;
  localparam int unsigned CTRL_WIN_LSB  = 1;
  localparam int unsigned CTRL_PER_LSB  = 4;
  localparam int unsigned CTRL_CLK_LSB  = 9;
  localparam logic [11:0] CTRL_RESET    = 12'h000;

  // status register fields
  localparam int unsigned STAT_RUN      = 0;
  localparam int unsigned STAT_SRC_LSB  = 1;
  localparam int unsigned STAT_WIN_LSB  = 4;
  localparam int unsigned STAT_PER_LSB  = 7;
  localparam int unsigned STAT_EXP_LSB  = 12;
  localparam int unsigned STAT_KEY      = 17;
  localparam int unsigned STAT_WINSW    = 18;
  localparam int unsigned STAT_PERSW    = 19;
  localparam int unsigned STAT_RSVD     = 20;

  // codes
  localparam logic [2:0]  CCS_LF        = 3'h0;
  localparam logic [2:0]  CCS_MF        = 3'h1;
  localparam logic [2:0]  CCS_SEC       = 3'h2;
  localparam logic [2:0]  CCS_SW        = 3'h7;
  localparam logic [2:0]  CWS_SW        = 3'h7;
  localparam logic [2:0]  CWS_OPEN      = 3'h6;
  localparam logic [1:0]  MODE_ALWAYS   = 2'h3;
  localparam logic [1:0]  MODE_AWAKE   = 2'h2;
  localparam logic [1:0]  MODE_SEN      = 2'h1;
  localparam logic [1:0]  MODE_OFF      = 2'h0;
  localparam logic [4:0]  CPS_MAX_FIX   = 5'h12;
  localparam logic [4:0]  CPS_SW        = 5'h1f;
  localparam logic [4:0]  PER_SW_INIT   = 5'h0b;
  localparam logic [4:0]  EXP_OFFSET    = 5'h05;
  localparam logic [4:0]  EXP_MIN       = 5'h05;

  typedef enum logic [2:0] {
    WDCFG_SRC_NONE,
    WDCFG_SRC_LF,
    WDCFG_SRC_MF,
    WDCFG_SRC_SEC
  } wdcfg_src_e;

  typedef struct packed {
    logic [2:0] ccs;
    logic [2:0] cws;
    logic [1:0] mode;
    logic [4:0] cps;
  } wdcfg_cfg_s;

  typedef struct packed {
    logic       run;
    wdcfg_src_e src;
    logic [2:0] window;
    logic [4:0] exponent;
    logic       keyed;
    logic       win_sw;
    logic       per_sw;
    logic       reserved;
  } wdcfg_dec_s;

  function automatic wdcfg_cfg_s wdcfg_split(input logic [13:0] w);
    wdcfg_cfg_s c;
    c.ccs  = w[CCS_LSB +: 3];
    c.cws  = w[CWS_LSB +: 3];
    c.mode = w[MODE_LSB +: 2];
    c.cps  = w[CPS_LSB +: 5];
    return c;
  endfunction

  function automatic logic [4:0] wdcfg_por_period(input logic [4:0] cps);
    return (cps == CPS_SW) ? PER_SW_INIT : cps;
  endfunction

endpackage

/* File: logic/wdcfg_top.sv */
// Purpose: watchdog configuration word decoder with wishbone register access
// Assumes: configuration word is valid on cfg_word_i while rst_i is high
// Notes:   classic wishbone slave, answers every access one cycle after it starts
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/100ps
module wdcfg_top (
  // clock and reset
  input  wire  logic                          clk_i,
  input  wire  logic                          rst_i,
  // nonvolatile configuration and core state
  input  wire  logic [wdcfg_pkg::CFG_W-1:0]   cfg_word_i,
  input  wire  logic                          sleep_i,
  // wishbone slave
  input  wire  logic                          cyc_i,
  input  wire  logic                          stb_i,
  input  wire  logic                          we_i,
  input  wire  logic [wdcfg_pkg::ADR_W-1:0]   adr_i,
  input  wire  logic [3:0]                    sel_i,
  input  wire  logic [31:0]                   dat_i,
  output logic [31:0]                         dat_o,
  output logic                                ack_o,
  // decoded watchdog settings
  output logic                                wdt_run_o,
  output wdcfg_pkg::wdcfg_src_e               wdt_src_o,
  output logic [2:0]                          wdt_window_o,
  output logic [4:0]                          wdt_period_o,
  output logic [4:0]                          wdt_exponent_o,
  output logic                                wdt_keyed_o
);
  import wdcfg_pkg::*;

  logic [CFG_W-1:0] cfg_word_reg;
  wdcfg_cfg_s       cfg;
  logic             sen_reg;
  logic [2:0]       sw_win_reg;
  logic [2:0]       sw_clk_reg;
  logic [4:0]       period_reg;
  wdcfg_dec_s       dec;
  logic [15:0]      idx;
  logic             access;
  logic             wr;
  logic [31:0]      wmask;
  logic [31:0]      ctrl_view;
  logic [31:0]      stat_view;
  logic [31:0]      rd_next;

  assign cfg    = wdcfg_split(cfg_word_reg);
  assign idx    = adr_i[ADR_W-1:2];
  assign access = cyc_i & stb_i & ~ack_o;
  assign wr     = access & we_i & (idx == IDX_CTRL);

  // per-lane write mask from the byte selects
  for (genvar b = 0; b < 4; b++) begin : g_mask
    assign wmask[8*b +: 8] = {8{sel_i[b]}};
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_word_reg <= cfg_word_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sen_reg <= CTRL_RESET[CTRL_SEN];
    end else if (wr) begin
      sen_reg <= (dat_i[CTRL_SEN] & wmask[CTRL_SEN]) | (sen_reg & ~wmask[CTRL_SEN]);
    end
  end

  // clock choice, writable only under software control
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sw_clk_reg <= CTRL_RESET[CTRL_CLK_LSB +: 3];
    end else if (wr && (cfg.ccs == CCS_SW)) begin
      sw_clk_reg <= (dat_i[CTRL_CLK_LSB +: 3] & wmask[CTRL_CLK_LSB +: 3]) |
                    (sw_clk_reg & ~wmask[CTRL_CLK_LSB +: 3]);
    end
  end

  // window value
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sw_win_reg <= cfg_word_i[CWS_LSB +: 3];
    end else if (wr && dec.win_sw) begin
      sw_win_reg <= (dat_i[CTRL_WIN_LSB +: 3] & wmask[CTRL_WIN_LSB +: 3]) |
                    (sw_win_reg & ~wmask[CTRL_WIN_LSB +: 3]);
    end
  end

  // run-time period field
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      period_reg <= wdcfg_por_period(cfg_word_i[CPS_LSB +: 5]);
    end else if (wr && dec.per_sw) begin
      period_reg <= (dat_i[CTRL_PER_LSB +: 5] & wmask[CTRL_PER_LSB +: 5]) |
                    (period_reg & ~wmask[CTRL_PER_LSB +: 5]);
    end
  end

  wdcfg_decode u_decode (
    .cfg_i    (cfg),
    .sen_i    (sen_reg),
    .sw_clk_i (sw_clk_reg),
    .sw_win_i (sw_win_reg),
    .period_i (period_reg),
    .sleep_i  (sleep_i),
    .dec_o    (dec)
  );

  // registered settings toward the timer, one flop group per concern
  // run state follows mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdt_run_o <= 1'b0;
    end else begin
      // a reserved source has no reference, so it never runs
      wdt_run_o <= dec.run & ~dec.reserved;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdt_src_o <= WDCFG_SRC_NONE;
    end else begin
      wdt_src_o <= dec.src;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdt_window_o <= 3'h0;
    end else begin
      wdt_window_o <= dec.window;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdt_period_o <= 5'h00;
    end else begin
      wdt_period_o <= period_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdt_exponent_o <= EXP_MIN;
    end else begin
      wdt_exponent_o <= dec.exponent;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdt_keyed_o <= 1'b0;
    end else begin
      wdt_keyed_o <= dec.keyed;
    end
  end

  // register views
  always_comb begin
    ctrl_view                       = '0;
    ctrl_view[CTRL_SEN]             = sen_reg;
    ctrl_view[CTRL_WIN_LSB +: 3]    = sw_win_reg;
    ctrl_view[CTRL_PER_LSB +: 5]    = period_reg;
    ctrl_view[CTRL_CLK_LSB +: 3]    = sw_clk_reg;
    stat_view                       = '0;
    stat_view[STAT_RUN]             = wdt_run_o;
    stat_view[STAT_SRC_LSB +: 3]    = wdt_src_o;
    stat_view[STAT_WIN_LSB +: 3]    = wdt_window_o;
    stat_view[STAT_PER_LSB +: 5]    = wdt_period_o;
    stat_view[STAT_EXP_LSB +: 5]    = wdt_exponent_o;
    stat_view[STAT_KEY]             = wdt_keyed_o;
    stat_view[STAT_WINSW]           = dec.win_sw;
    stat_view[STAT_PERSW]           = dec.per_sw;
    stat_view[STAT_RSVD]            = dec.reserved;
    unique case (idx)
      IDX_CFG_WORD: rd_next = {18'h0_0000, cfg_word_reg};
      IDX_CTRL:     rd_next = ctrl_view;
      IDX_STAT:     rd_next = stat_view;
      default:      rd_next = 32'h0000_0000;
    endcase
  end

  // one-cycle answer; ack in access keeps a held strobe from a second answer in the very next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= access;
    end
  end

  // read data stands with ack only; unmapped reads give zero, writes there are dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else begin
      dat_o <= (access && !we_i) ? rd_next : 32'h0000_0000;
    end
  end

endmodule
